// ===== rtl/lkcd_defines.vh
`ifndef LKCD_DEFINES_VH
`define LKCD_DEFINES_VH

// ==========================================================
// Byte classes
`define LKCD_CMD_BIT        7
`define LKCD_DISP_PTR_MASK  8'hf0
`define LKCD_DISP_PTR_CODE  8'h00
`define LKCD_KEY_PTR_MASK   8'hfc
`define LKCD_KEY_PTR_CODE   8'h20
`define LKCD_KEY_PTR_LAST   2'h2
`define LKCD_KEY_PTR_FIRST  2'h0
`define LKCD_IRQ_PTR_CODE   8'h30
`define LKCD_SYS_CMD_MASK   8'hfc
`define LKCD_SYS_CMD_CODE   8'h80
`define LKCD_MODE_CMD_MASK  8'hf8
`define LKCD_MODE_CMD_CODE  8'ha0
`define LKCD_SCAN_CMD_MASK  8'hf8
`define LKCD_SCAN_CMD_CODE  8'hf8

// ==========================================================
// Field positions
`define LKCD_SYS_NORMAL_BIT 0
`define LKCD_SYS_DISP_BIT   1
`define LKCD_MODE_MUX_BIT   0
`define LKCD_MODE_PIN_BIT   1
`define LKCD_MODE_POL_BIT   2

// ==========================================================
// Reset values
`define LKCD_DISP_PTR_RST   4'h0
`define LKCD_KEY_PTR_RST    2'h0
`define LKCD_NORMAL_RST     1'b0
`define LKCD_DISP_ON_RST    1'b0
`define LKCD_MUX_RST        1'b0
`define LKCD_PIN_RST        1'b0
`define LKCD_POL_RST        1'b0
`define LKCD_SCAN_RST       3'h0
`define LKCD_CYCLES_RST     5'h02

// ==========================================================
// Pointer spaces
`define LKCD_SPACE_DISP     2'h0
`define LKCD_SPACE_KEY      2'h1
`define LKCD_SPACE_IRQ      2'h2

// ==========================================================
// Link framing
`define LKCD_ACK_CNT        4'h8
`define LKCD_END_CNT        4'h9

`endif

// ===== rtl/lkcd_link.v
`timescale 1ns/1ps
`include "lkcd_defines.vh"

module lkcd_link #(
  parameter [6:0] SLAVE_ADDR = 7'h70
) (
  // Clock and reset
  input  wire       mclk,
  input  wire       reset,
  // Pins
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_oe,
  // Byte side
  input  wire [7:0] tx_byte,
  output reg        frame_start,
  output reg        rx_valid,
  output reg        rx_first,
  output reg  [7:0] rx_byte,
  output reg        rd_ack
);

  // ==========================================================
  // Synchronisers
  reg       scl_m;
  reg       scl_s;
  reg       scl_d;
  reg       sda_m;
  reg       sda_s;
  reg       sda_d;
  reg       active;
  reg       addr_phase;
  reg       rd_mode;
  reg       tx_on;
  reg       got_first;
  reg [3:0] bit_cnt;
  reg [7:0] shreg;
  reg [7:0] txreg;

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  // ==========================================================
  // Byte framing, counted on rising clock edges
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      sda_oe      <= 1'b0;
      frame_start <= 1'b0;
      rx_valid    <= 1'b0;
      rx_first    <= 1'b0;
      rx_byte     <= 8'h00;
      rd_ack      <= 1'b0;
      active      <= 1'b0;
      addr_phase  <= 1'b0;
      rd_mode     <= 1'b0;
      tx_on       <= 1'b0;
      got_first   <= 1'b0;
      bit_cnt     <= 4'h0;
      shreg       <= 8'h00;
      txreg       <= 8'h00;
    end else begin
      frame_start <= 1'b0;
      rx_valid    <= 1'b0;
      rd_ack      <= 1'b0;
      if (start_c) begin
        active      <= 1'b1;
        addr_phase  <= 1'b1;
        tx_on       <= 1'b0;
        got_first   <= 1'b0;
        bit_cnt     <= 4'h0;
        sda_oe      <= 1'b0;
        frame_start <= 1'b1;
      end else if (stop_c) begin
        active <= 1'b0;
        tx_on  <= 1'b0;
        sda_oe <= 1'b0;
      end else if (active && scl_rise) begin
        if (bit_cnt < `LKCD_ACK_CNT) begin
          shreg   <= {shreg[6:0], sda_s};
          bit_cnt <= bit_cnt + 4'h1;
        end else if (bit_cnt == `LKCD_ACK_CNT) begin
          bit_cnt <= `LKCD_END_CNT;
          if (tx_on) begin
            if (!sda_s) begin
              rd_ack <= 1'b1;
            end else begin
              tx_on  <= 1'b0;
              active <= 1'b0;
            end
          end
        end
      end else if (active && scl_fall) begin
        if (bit_cnt == `LKCD_ACK_CNT) begin
          if (addr_phase) begin
            if (shreg[7:1] == SLAVE_ADDR) begin
              sda_oe  <= 1'b1;
              rd_mode <= shreg[0];
            end else begin
              active <= 1'b0;
            end
          end else if (!rd_mode) begin
            sda_oe    <= 1'b1;
            rx_valid  <= 1'b1;
            rx_byte   <= shreg;
            rx_first  <= ~got_first;
            got_first <= 1'b1;
          end else begin
            sda_oe <= 1'b0;
          end
        end else if (bit_cnt == `LKCD_END_CNT) begin
          bit_cnt    <= 4'h0;
          addr_phase <= 1'b0;
          if (rd_mode && (addr_phase || tx_on)) begin
            tx_on  <= 1'b1;
            txreg  <= {tx_byte[6:0], 1'b0};
            sda_oe <= ~tx_byte[7];
          end else begin
            sda_oe <= 1'b0;
          end
        end else if (tx_on && bit_cnt != 4'h0) begin
          sda_oe <= ~txreg[7];
          txreg  <= {txreg[6:0], 1'b0};
        end
      end
    end
  end

endmodule

// ===== rtl/lkcd_command_decoder.v
// Operation
// - 0x0n byte loads display RAM pointer
// - Pointer 0x30 selects interrupt flag reads
// - System set: bit0 normal, bit1 display
// - Mode bit0 picks four or eight commons
// - Mode bit1 makes shared pin interrupt output
// - Mode bit2 sets interrupt output polarity
// - 0xf8 family sets key scan period
// - Undefined encodings change nothing at all
// - Period code maps to cycles by mode
// - Bytes after a command are discarded
// - Read pointers wrap within their space
`timescale 1ns/1ps
`include "lkcd_defines.vh"

module lkcd_command_decoder #(
  parameter [6:0] SLAVE_ADDR = 7'h70
) (
  // Clock and reset
  input  wire       mclk,
  input  wire       reset,
  // Serial link pins
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out,
  output wire       sda_oe,
  // Read data sources
  input  wire [7:0] ram_rd_data,
  input  wire [7:0] key_rd_data,
  input  wire       irq_flag,
  // Display RAM writes
  output reg        ram_wr_en,
  output reg  [3:0] ram_wr_addr,
  output reg  [7:0] ram_wr_data,
  // Pointers
  output reg  [3:0] display_pointer_bits,
  output reg  [1:0] key_pointer_bits,
  output reg  [1:0] pointer_space,
  // Settings
  output reg        normal_mode,
  output reg        display_on,
  output reg        mux_eight_com,
  output reg        seg_pin_is_irq,
  output reg        irq_polarity,
  output reg  [2:0] scan_period_code,
  output reg  [4:0] scan_period_cycles,
  output reg        irq_pin_level
);

  // ==========================================================
  // Link framing
  wire       frame_start;
  wire       rx_valid;
  wire       rx_first;
  wire [7:0] rx_byte;
  wire       rd_ack;
  reg  [7:0] tx_byte;
  reg        discard;

  lkcd_link #(
    .SLAVE_ADDR (SLAVE_ADDR)
  ) u_link (
    .mclk        (mclk),
    .reset       (reset),
    .scl_in      (scl_in),
    .sda_in      (sda_in),
    .sda_oe      (sda_oe),
    .tx_byte     (tx_byte),
    .frame_start (frame_start),
    .rx_valid    (rx_valid),
    .rx_first    (rx_first),
    .rx_byte     (rx_byte),
    .rd_ack      (rd_ack)
  );

  // ==========================================================
  // Read data selection
  always @* begin
    case (pointer_space)
      `LKCD_SPACE_DISP: tx_byte = ram_rd_data;
      `LKCD_SPACE_KEY:  tx_byte = key_rd_data;
      `LKCD_SPACE_IRQ:  tx_byte = {7'h00, irq_flag};
      default:          tx_byte = 8'h00;
    endcase
  end

  // ==========================================================
  // Byte classification
  wire is_cmd   = rx_byte[`LKCD_CMD_BIT];
  wire is_disp  = (rx_byte & `LKCD_DISP_PTR_MASK) == `LKCD_DISP_PTR_CODE;
  wire is_key   = ((rx_byte & `LKCD_KEY_PTR_MASK) == `LKCD_KEY_PTR_CODE)
                  && (rx_byte[1:0] <= `LKCD_KEY_PTR_LAST);
  wire is_irq   = rx_byte == `LKCD_IRQ_PTR_CODE;
  wire is_sys   = (rx_byte & `LKCD_SYS_CMD_MASK) == `LKCD_SYS_CMD_CODE;
  wire is_mode  = (rx_byte & `LKCD_MODE_CMD_MASK) == `LKCD_MODE_CMD_CODE;
  wire is_scan  = (rx_byte & `LKCD_SCAN_CMD_MASK) == `LKCD_SCAN_CMD_CODE;
  wire take_hdr = rx_valid && rx_first;
  wire take_dat = rx_valid && !rx_first && !discard
                  && pointer_space == `LKCD_SPACE_DISP;

  // ==========================================================
  // Decoder and settings
  // reset defaults
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      sda_out              <= 1'b0;
      discard              <= 1'b0;
      ram_wr_en            <= 1'b0;
      ram_wr_addr          <= `LKCD_DISP_PTR_RST;
      ram_wr_data          <= 8'h00;
      display_pointer_bits <= `LKCD_DISP_PTR_RST;
      key_pointer_bits     <= `LKCD_KEY_PTR_RST;
      pointer_space        <= `LKCD_SPACE_DISP;
      normal_mode          <= `LKCD_NORMAL_RST;
      display_on           <= `LKCD_DISP_ON_RST;
      mux_eight_com        <= `LKCD_MUX_RST;
      seg_pin_is_irq       <= `LKCD_PIN_RST;
      irq_polarity         <= `LKCD_POL_RST;
      scan_period_code     <= `LKCD_SCAN_RST;
      scan_period_cycles   <= `LKCD_CYCLES_RST;
      irq_pin_level        <= 1'b1;
    end else begin
      // Open drain: the pin is only ever pulled low
      sda_out   <= 1'b0;
      ram_wr_en <= 1'b0;
      if (frame_start) begin
        discard <= 1'b0;
      end
      if (take_hdr) begin
        discard <= is_cmd | ~(is_disp | is_key | is_irq);
        if (!is_cmd) begin
          if (is_disp) begin
            display_pointer_bits <= rx_byte[3:0];
            pointer_space        <= `LKCD_SPACE_DISP;
          end else if (is_key) begin
            key_pointer_bits <= rx_byte[1:0];
            pointer_space    <= `LKCD_SPACE_KEY;
          end else if (is_irq) begin
            pointer_space <= `LKCD_SPACE_IRQ;
          end
        end else if (is_sys) begin
          normal_mode <= rx_byte[`LKCD_SYS_NORMAL_BIT];
          display_on  <= rx_byte[`LKCD_SYS_DISP_BIT];
        end else if (is_mode) begin
          mux_eight_com  <= rx_byte[`LKCD_MODE_MUX_BIT];
          seg_pin_is_irq <= rx_byte[`LKCD_MODE_PIN_BIT];
          irq_polarity   <= rx_byte[`LKCD_MODE_POL_BIT];
        end else if (is_scan) begin
          scan_period_code <= rx_byte[2:0];
        end
      end else if (take_dat) begin
        ram_wr_en            <= 1'b1;
        ram_wr_addr          <= display_pointer_bits;
        ram_wr_data          <= rx_byte;
        display_pointer_bits <= display_pointer_bits + 4'h1;
      end else if (rd_ack) begin
        if (pointer_space == `LKCD_SPACE_DISP) begin
          display_pointer_bits <= display_pointer_bits + 4'h1;
        end else if (pointer_space == `LKCD_SPACE_KEY) begin
          if (key_pointer_bits == `LKCD_KEY_PTR_LAST) begin
            key_pointer_bits <= `LKCD_KEY_PTR_FIRST;
          end else begin
            key_pointer_bits <= key_pointer_bits + 2'h1;
          end
        end
      end
      if (mux_eight_com) begin
        scan_period_cycles <= {1'b0, scan_period_code, 1'b1};
      end else begin
        scan_period_cycles <= {1'b0, scan_period_code, 1'b0} + 5'h02;
      end
      irq_pin_level <= irq_polarity ? irq_flag : ~irq_flag;
    end
  end

endmodule

// ===== verification/lkcd_i2c_host.sv
`timescale 1ns/1ps
// ==========================================================
// Host master, open drain; clock stands high between frames
module lkcd_i2c_host (
  // Pins
  output logic scl,
  output logic sda_rel,
  input  wire  sda
);
  initial begin
    scl     = 1'b1;
    sda_rel = 1'b1;
  end
  // Also serves as repeated start
  task start_c();
    sda_rel = 1'b1;
    #31.25 scl = 1'b1;
    #31.25 sda_rel = 1'b0;
    #31.25 scl = 1'b0;
    #31.25;
  endtask
  task stop_c();
    sda_rel = 1'b0;
    #31.25 scl = 1'b1;
    #31.25 sda_rel = 1'b1;
    #62.5;
  endtask
  // Data moves only while clock is low
  task bit_io(input logic b, output logic r);
    sda_rel = b;
    #31.25 scl = 1'b1;
    #31.25 r = sda;
    #31.25 scl = 1'b0;
    #31.25;
  endtask
  task byte_io(input logic [7:0] d, input logic a,
               output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a, k);
  endtask
endmodule

// ===== verification/lkcd_command_decoder_assertions.sv
`timescale 1ns/1ps
module lkcd_cmd_checker (
  // Clock and reset
  input wire       mclk,
  input wire       reset,
  // Watched ports
  input wire       irq_flag,
  input wire       ram_wr_en,
  input wire [3:0] ram_wr_addr,
  input wire [3:0] display_pointer_bits,
  input wire [1:0] key_pointer_bits,
  input wire [1:0] pointer_space,
  input wire       mux_eight_com,
  input wire       irq_polarity,
  input wire [2:0] scan_period_code,
  input wire [4:0] scan_period_cycles,
  input wire       irq_pin_level
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  a_wr_one_cycle: assert property (
    ram_wr_en |=> !ram_wr_en) else $error("write strobe too long");
  a_ptr_follows: assert property (
    ram_wr_en |-> ##[0:1] display_pointer_bits == ram_wr_addr + 4'h1)
    else $error("pointer did not step after write");
  a_key_in_range: assert property (
    key_pointer_bits != 2'h3) else $error("key pointer out of range");
  a_key_wrap: assert property (
    (pointer_space == 2'h1 && $stable(pointer_space)
     && !$stable(key_pointer_bits)) |-> key_pointer_bits ==
    (($past(key_pointer_bits) == 2'h2) ? 2'h0
                                       : $past(key_pointer_bits) + 2'h1))
    else $error("key pointer step wrong");
  a_space_legal: assert property (
    pointer_space != 2'h3) else $error("pointer space illegal");
  a_cycles_four: assert property (
    !$past(mux_eight_com) |-> scan_period_cycles ==
    {1'b0, $past(scan_period_code), 1'b0} + 5'h2)
    else $error("scan cycles wrong in four common mode");
  a_cycles_eight: assert property (
    $past(mux_eight_com) |->
    scan_period_cycles == {1'b0, $past(scan_period_code), 1'b1})
    else $error("scan cycles wrong in eight common mode");
  a_irq_follow: assert property (
    !$past(reset) |->
    irq_pin_level == ($past(irq_flag) ~^ $past(irq_polarity)))
    else $error("interrupt pin level wrong");
endmodule

bind lkcd_command_decoder lkcd_cmd_checker u_lkcd_cmd_checker (
  .mclk(mclk), .reset(reset), .irq_flag(irq_flag),
  .ram_wr_en(ram_wr_en), .ram_wr_addr(ram_wr_addr),
  .display_pointer_bits(display_pointer_bits),
  .key_pointer_bits(key_pointer_bits), .pointer_space(pointer_space),
  .mux_eight_com(mux_eight_com), .irq_polarity(irq_polarity),
  .scan_period_code(scan_period_code),
  .scan_period_cycles(scan_period_cycles), .irq_pin_level(irq_pin_level));

// ===== verification/tb_lkcd_command_decoder.sv
`timescale 1ns/1ps
module tb_lkcd_command_decoder;
  // ==========================================================
  // Signals
  logic        mclk, reset, irq_flag;
  wire         scl, sda_rel, sda_oe, sda_out, ram_wr_en;
  wire         normal_mode, display_on, mux_eight_com;
  wire         seg_pin_is_irq, irq_polarity, irq_pin_level;
  wire  [3:0]  ram_wr_addr, display_pointer_bits;
  wire  [7:0]  ram_wr_data;
  wire  [1:0]  key_pointer_bits, pointer_space;
  wire  [2:0]  scan_period_code;
  wire  [4:0]  scan_period_cycles;
  int          n_mismatch, tests_run, cycles;
  logic [11:0] wq[$];
  // Pull-up on the data line
  wire         sda = sda_rel & (sda_oe ? sda_out : 1'b1);

  lkcd_i2c_host u_lkcd_i2c_host (.scl(scl), .sda_rel(sda_rel), .sda(sda));
  lkcd_command_decoder u_lkcd_command_decoder (
    .mclk(mclk), .reset(reset), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe),
    .ram_rd_data({4'ha, display_pointer_bits}),
    .key_rd_data({6'h30, key_pointer_bits}), .irq_flag(irq_flag),
    .ram_wr_en(ram_wr_en), .ram_wr_addr(ram_wr_addr),
    .ram_wr_data(ram_wr_data), .display_pointer_bits(display_pointer_bits),
    .key_pointer_bits(key_pointer_bits), .pointer_space(pointer_space),
    .normal_mode(normal_mode), .display_on(display_on),
    .mux_eight_com(mux_eight_com), .seg_pin_is_irq(seg_pin_is_irq),
    .irq_polarity(irq_polarity), .scan_period_code(scan_period_code),
    .scan_period_cycles(scan_period_cycles), .irq_pin_level(irq_pin_level));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (ram_wr_en === 1'b1) wq.push_back({ram_wr_addr, ram_wr_data});
    cycles <= cycles + 1;
    // Whole run needs about 17000 cycles
    if (cycles == 40000) begin
      n_mismatch++;
      end_sim();
    end
  end
  // ==========================================================
  // Helpers
  function logic [15:0] sets();
    sets = {normal_mode, display_on, mux_eight_com, seg_pin_is_irq,
            irq_polarity, scan_period_code, display_pointer_bits,
            key_pointer_bits, pointer_space};
  endfunction
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task end_sim();
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [23:0] d, input int n);
    logic [7:0] q;
    logic       k;
    u_lkcd_i2c_host.start_c();
    u_lkcd_i2c_host.byte_io(8'he0, 1'b1, q, k);
    chk({15'h0, k}, 16'h0);
    for (int i = 0; i < n; i++)
      u_lkcd_i2c_host.byte_io(d[23-8*i -: 8], 1'b1, q, k);
    u_lkcd_i2c_host.stop_c();
    repeat (20) @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] p, input logic [31:0] e);
    logic [7:0] q;
    logic       k;
    u_lkcd_i2c_host.start_c();
    u_lkcd_i2c_host.byte_io(8'he0, 1'b1, q, k);
    u_lkcd_i2c_host.byte_io(p, 1'b1, q, k);
    u_lkcd_i2c_host.start_c();
    u_lkcd_i2c_host.byte_io(8'he1, 1'b1, q, k);
    for (int i = 0; i < 4; i++) begin
      u_lkcd_i2c_host.byte_io(8'hff, i == 3, q, k);
      chk({8'h0, q}, {8'h0, e[31-8*i -: 8]});
    end
    u_lkcd_i2c_host.stop_c();
    repeat (20) @(negedge mclk);
  endtask
  // ==========================================================
  // Scenarios
  task t_reset();
    reset = 1'b1;
    repeat (16) @(negedge mclk);
    reset = 1'b0;
    repeat (4) @(negedge mclk);
    chk(sets(), 16'h0);
    chk({11'h0, scan_period_cycles}, 16'h2);
  endtask
  task t_system();
    wr({8'h83, 16'h0}, 1);
    chk(sets(), 16'hc000);
    wr({8'h81, 8'ha7, 8'h0}, 2);
    chk(sets(), 16'h8000);
  endtask
  task automatic t_mode();
    for (int i = 0; i < 8; i++) begin
      wr({8'ha0 | 8'(i), 16'h0}, 1);
      chk(sets(), {2'b10, i[0], i[1], i[2], 11'h0});
    end
  endtask
  task automatic t_scan();
    for (int m = 0; m < 2; m++)
      for (int n = 0; n < 8; n++) begin
        wr({8'ha0 | 8'(m), 8'hf8 | 8'(n), 8'h0}, 1);
        wr({8'hf8 | 8'(n), 16'h0}, 1);
        chk({13'h0, scan_period_code}, 16'(n));
        chk({11'h0, scan_period_cycles}, 16'(2 * n + 2 - m));
      end
  endtask
  task automatic t_undef();
    logic [7:0]  u[5] = '{8'h84, 8'hc0, 8'hf0, 8'h40, 8'h23};
    logic [15:0] s;
    s = sets();
    foreach (u[i]) begin
      wr({u[i], 8'h83, 8'h0}, 2);
      chk(sets(), s);
    end
  endtask
  task t_ram();
    wq.delete();
    wr({8'h0f, 8'h5a, 8'ha5}, 3);
    chk(16'(wq.size()), 16'h2);
    chk({4'h0, wq[0]}, 16'h0f5a);
    chk({4'h0, wq[1]}, 16'h00a5);
  endtask
  task t_irq();
    irq_flag = 1'b1;
    wr({8'h30, 16'h0}, 1);
    chk({14'h0, pointer_space}, 16'h2);
    chk({15'h0, irq_pin_level}, 16'h0);
    rd(8'h30, 32'h01010101);
    wr({8'ha5, 16'h0}, 1);
    chk({15'h0, irq_pin_level}, 16'h1);
  endtask

  initial begin
    irq_flag = 1'b0;
    cycles   = 0;
    t_reset();
    t_system();
    t_mode();
    t_scan();
    t_undef();
    t_ram();
    rd(8'h0e, 32'haeafa0a1);
    rd(8'h20, 32'hc0c1c2c0);
    t_irq();
    t_reset();
    end_sim();
  end
endmodule
